//--- include/ilc_pkg.sv
`default_nettype none
package ilc_pkg;
  localparam int unsigned NUM_LANES = 8;
  localparam int unsigned ILA_OCTETS = 14;
  localparam int unsigned OCT_W = ILA_OCTETS * 8;
  // Register bus map
  localparam logic [11:0] ADDR_CORE_CFG = 12'h000;
  localparam logic [2:0] LANE_REGION = 3'h4;
  localparam int unsigned REGION_LSB = 9;
  localparam int unsigned LANE_SEL_LSB = 6;
  localparam int unsigned REG_SEL_LSB = 2;
  localparam logic [3:0] REG_LANE_IDENTIFIER = 4'h0;
  localparam logic [3:0] REG_CFG0 = 4'h1;
  localparam logic [3:0] REG_CFG1 = 4'h2;
  localparam logic [3:0] REG_CFG2 = 4'h3;
  localparam logic [3:0] REG_CFG3 = 4'h4;
  localparam logic [3:0] REG_CFG4 = 4'h5;
  localparam logic [3:0] REG_CFG5 = 4'h6;
  localparam logic [3:0] REG_CFG6 = 4'h7;
  // Core configuration register fields
  localparam int unsigned CORE_TX_BIT = 0;
  localparam int unsigned CORE_SCR_BIT = 1;
  localparam int unsigned CORE_SUB_LSB = 4;
  localparam int unsigned CORE_L_LSB = 8;
  localparam int unsigned CORE_F_LSB = 16;
  localparam int unsigned CORE_K_LSB = 24;
  localparam logic [31:0] CORE_WR_MASK = 32'h1FFF_1F73;
  localparam logic [31:0] CORE_RST = 32'h0000_0000;
  localparam logic [2:0] JESDV_REV_B = 3'h1;
  // Per-lane register fields
  localparam int unsigned LANEID_LSB = 0;
  localparam int unsigned VER_LSB = 8;
  localparam int unsigned SUB_LSB = 0;
  localparam int unsigned F_LSB = 0;
  localparam int unsigned K_LSB = 0;
  localparam int unsigned L_LSB = 24;
  localparam int unsigned LID_LSB = 16;
  localparam int unsigned BID_LSB = 8;
  localparam int unsigned DID_LSB = 0;
  localparam int unsigned CS_LSB = 24;
  localparam int unsigned NT_LSB = 16;
  localparam int unsigned N_LSB = 8;
  localparam int unsigned M_LSB = 0;
  localparam int unsigned CF_LSB = 24;
  localparam int unsigned HD_BIT = 16;
  localparam int unsigned S_LSB = 8;
  localparam int unsigned SCR_BIT = 0;
  localparam int unsigned CHK_LSB = 16;
  localparam int unsigned RES2_LSB = 8;
  localparam int unsigned RES1_LSB = 0;
  // Octet positions in the alignment configuration sequence
  localparam int unsigned OCT_DID = 0;
  localparam int unsigned OCT_BID = 1;
  localparam int unsigned OCT_LID = 2;
  localparam int unsigned OCT_L = 3;
  localparam int unsigned OCT_F = 4;
  localparam int unsigned OCT_K = 5;
  localparam int unsigned OCT_M = 6;
  localparam int unsigned OCT_CSN = 7;
  localparam int unsigned OCT_NP = 8;
  localparam int unsigned OCT_S = 9;
  localparam int unsigned OCT_CF = 10;
  localparam int unsigned OCT_RES1 = 11;
  localparam int unsigned OCT_RES2 = 12;
  localparam int unsigned OCT_CHK = 13;
  localparam int unsigned POS_HI3 = 5;
  localparam int unsigned POS_CS = 6;
  localparam int unsigned POS_TOP = 7;

  typedef struct packed {
    logic [4:0] lane_identifier;
    logic [2:0] jesdv;
    logic [2:0] subclass;
    logic [7:0] f;
    logic [4:0] k;
    logic [4:0] l;
    logic [4:0] lid;
    logic [3:0] bid;
    logic [7:0] did;
    logic [1:0] cs;
    logic [4:0] nt;
    logic [4:0] n;
    logic [7:0] m;
    logic [4:0] cf;
    logic       hd;
    logic [4:0] s;
    logic       scr;
    logic [7:0] chk;
    logic [7:0] res2;
    logic [7:0] res1;
  } ilc_lane_t;

  // Modulo-256 sum of the field values
  function automatic logic [7:0] ilc_fchk(input ilc_lane_t v);
    ilc_fchk = 8'(v.did) + 8'(v.bid) + 8'(v.lid) + 8'(v.scr) + 8'(v.l)
             + v.f + 8'(v.k) + v.m + 8'(v.cs) + 8'(v.n) + 8'(v.subclass)
             + 8'(v.nt) + 8'(v.jesdv) + 8'(v.s) + 8'(v.hd) + 8'(v.cf)
             + v.res1 + v.res2;
  endfunction
endpackage
`default_nettype wire

//--- verilog/ilc_lane.sv
`default_nettype none
module ilc_lane
  import ilc_pkg::*;
#(
  parameter logic [4:0] LANE_IDX = 5'h00
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             tx_mode,
  input  wire logic             scr_en,
  input  wire logic [2:0]       subclass,
  input  wire logic [4:0]       lanes_m1,
  input  wire logic [7:0]       f_m1,
  input  wire logic [4:0]       k_m1,
  input  wire logic             wr_en,
  input  wire logic [3:0]       wr_reg,
  input  wire logic [31:0]      wdata,
  input  wire logic             rx_valid,
  input  wire logic [OCT_W-1:0] rx_octets,
  output var  ilc_lane_t        lane_q
);
  localparam ilc_lane_t RST_Q = '{lane_identifier: LANE_IDX, default: '0};

  ilc_lane_t q_ff;
  ilc_lane_t nxt_q;

  always_comb
  begin
    nxt_q = q_ff;
    // RL1 identifier write
    if (wr_en && wr_reg == REG_LANE_IDENTIFIER)
      nxt_q.lane_identifier = wdata[LANEID_LSB +: 5];
    // RL15 only defined bits stored
    if (wr_en)
    begin
      unique case (wr_reg)
        REG_CFG3:
        begin
          nxt_q.bid = wdata[BID_LSB +: 4];
          nxt_q.did = wdata[DID_LSB +: 8];
        end
        REG_CFG4:
        begin
          nxt_q.cs = wdata[CS_LSB +: 2];
          nxt_q.nt = wdata[NT_LSB +: 5];
          nxt_q.n = wdata[N_LSB +: 5];
          nxt_q.m = wdata[M_LSB +: 8];
        end
        REG_CFG5:
        begin
          nxt_q.cf = wdata[CF_LSB +: 5];
          nxt_q.hd = wdata[HD_BIT];
          nxt_q.s = wdata[S_LSB +: 5];
        end
        REG_CFG6:
        begin
          nxt_q.res2 = wdata[RES2_LSB +: 8];
          nxt_q.res1 = wdata[RES1_LSB +: 8];
        end
        default:
        begin
        end
      endcase
    end
    // RL3 capture beats a same-cycle write
    if (!tx_mode && rx_valid)
    begin
      nxt_q.did = rx_octets[8*OCT_DID +: 8];
      nxt_q.bid = rx_octets[8*OCT_BID +: 4];
      nxt_q.lid = rx_octets[8*OCT_LID +: 5];
      nxt_q.l = rx_octets[8*OCT_L +: 5];
      nxt_q.scr = rx_octets[8*OCT_L + POS_TOP];
      nxt_q.f = rx_octets[8*OCT_F +: 8];
      nxt_q.k = rx_octets[8*OCT_K +: 5];
      nxt_q.m = rx_octets[8*OCT_M +: 8];
      nxt_q.n = rx_octets[8*OCT_CSN +: 5];
      nxt_q.cs = rx_octets[8*OCT_CSN + POS_CS +: 2];
      nxt_q.nt = rx_octets[8*OCT_NP +: 5];
      nxt_q.subclass = rx_octets[8*OCT_NP + POS_HI3 +: 3];
      nxt_q.s = rx_octets[8*OCT_S +: 5];
      nxt_q.jesdv = rx_octets[8*OCT_S + POS_HI3 +: 3];
      nxt_q.cf = rx_octets[8*OCT_CF +: 5];
      nxt_q.hd = rx_octets[8*OCT_CF + POS_TOP];
      nxt_q.res1 = rx_octets[8*OCT_RES1 +: 8];
      nxt_q.res2 = rx_octets[8*OCT_RES2 +: 8];
      nxt_q.chk = rx_octets[8*OCT_CHK +: 8];
    end
    // RL5 generated link parameters
    if (tx_mode)
    begin
      nxt_q.jesdv = JESDV_REV_B;
      nxt_q.subclass = subclass;
      nxt_q.f = f_m1;
      nxt_q.k = k_m1;
      // RL8 generated lane count and id
      nxt_q.l = lanes_m1;
      nxt_q.lid = q_ff.lane_identifier;
      // RL12 scrambling from config
      nxt_q.scr = scr_en;
      // RL13 checksum lags fields by one cycle
      nxt_q.chk = ilc_fchk(q_ff);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      q_ff <= RST_Q;
    else
      q_ff <= nxt_q;
  end

  assign lane_q = q_ff;
endmodule
`default_nettype wire

//--- verilog/ilc_ila_regs.sv
// What this block does
// RL1: Each lane has a 5-bit identifier, any value, resetting to its lane index.
// RL2: Software reprograms identifiers to stay distinct when links exceed eight lanes.
// RL3: On receive, lane registers load the parameters from that lane's alignment sequence.
// RL4: Word 0 holds version at 10:8 and subclass at 2:0.
// RL5: On transmit, words 0 to 2 unused; sent values come from core setup. Here the sent version is the constant JESDV_REV_B.
// RL6: Word 1 bits 7:0 report octets per frame minus one.
// RL7: Word 2 bits 4:0 report frames per multiframe minus one.
// RL8: Word 3 holds lanes minus one and lane_identifier; generated and read-only on transmit.
// RL9: Word 3 bank and device ids reset zero; transmit sends written values everywhere.
// RL10: Word 4 holds control bits, sample bits, resolution, converter count; reset zero.
// RL11: Word 5 holds control words, high-density flag, samples per converter minus one.
// RL12: Word 5 bit 0 is scrambling; on transmit filled by core, not writable.
// RL13: Word 6 bits 23:16 checksum; computed per lane on transmit, received otherwise.
// RL14: Word 6 spare bytes reset zero; on transmit sent on every lane.
// RL15: Reserved bits read zero and ignore writes.
//
// The plain strobed port and the address map were chosen for this implementation.
`default_nettype none
module ilc_ila_regs
  import ilc_pkg::*;
(
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  input  wire logic [11:0]                addr,
  input  wire logic [31:0]                wdata,
  input  wire logic                       wr_en,
  input  wire logic                       rd_en,
  output logic      [31:0]                rdata,
  input  wire logic [NUM_LANES-1:0]       rx_ila_valid,
  input  wire logic [NUM_LANES*OCT_W-1:0] rx_ila_octets,
  output logic      [NUM_LANES*OCT_W-1:0] tx_ila_octets
);
  typedef struct packed {
    logic [31:0]                core;
    logic [31:0]                rdata;
    logic [NUM_LANES*OCT_W-1:0] tx_oct;
  } ilc_top_t;

  ilc_top_t  s_ff;
  ilc_top_t  nxt_s;
  ilc_lane_t lane_q [NUM_LANES];
  logic [NUM_LANES-1:0] lane_wr;
  logic                 tx_mode;
  logic                 core_hit;
  logic                 lane_hit;
  logic [2:0]           lane_sel;
  logic [3:0]           reg_sel;
  logic                 cfg_bcast;

  assign tx_mode = s_ff.core[CORE_TX_BIT];
  assign core_hit = addr == ADDR_CORE_CFG;
  assign lane_sel = addr[LANE_SEL_LSB +: 3];
  assign reg_sel = addr[REG_SEL_LSB +: 4];
  // Misaligned or beyond-word-6 offsets fall to the unmapped answer
  assign lane_hit = addr[REGION_LSB +: 3] == LANE_REGION
                 && addr[1:0] == 2'b00
                 && reg_sel <= REG_CFG6;
  // RL9 transmit writes to words 3 to 6 reach every lane
  assign cfg_bcast = tx_mode && reg_sel >= REG_CFG3;

  for (genvar i = 0; i < NUM_LANES; i++)
  begin : g_lane
    assign lane_wr[i] = wr_en && lane_hit
                     && (lane_sel == 3'(i) || cfg_bcast);
    ilc_lane #(
      .LANE_IDX (5'(i))
    ) u_lane (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .tx_mode   (tx_mode),
      .scr_en    (s_ff.core[CORE_SCR_BIT]),
      .subclass  (s_ff.core[CORE_SUB_LSB +: 3]),
      .lanes_m1  (s_ff.core[CORE_L_LSB +: 5]),
      .f_m1      (s_ff.core[CORE_F_LSB +: 8]),
      .k_m1      (s_ff.core[CORE_K_LSB +: 5]),
      .wr_en     (lane_wr[i]),
      .wr_reg    (reg_sel),
      .wdata     (wdata),
      .rx_valid  (rx_ila_valid[i]),
      .rx_octets (rx_ila_octets[i*OCT_W +: OCT_W]),
      .lane_q    (lane_q[i])
    );
  end

  // Read view of one lane word; reserved bits stay zero
  function automatic logic [31:0] rd_word(
    input ilc_lane_t  v,
    input logic [3:0] r,
    input logic       tx
  );
    logic [31:0] w;
    w = '0;
    unique case (r)
      REG_LANE_IDENTIFIER:
        w[LANEID_LSB +: 5] = v.lane_identifier;
      // RL4 version and subclass
      REG_CFG0:
      begin
        if (!tx)
        begin
          w[VER_LSB +: 3] = v.jesdv;
          w[SUB_LSB +: 3] = v.subclass;
        end
      end
      // RL6 octets per frame
      REG_CFG1:
      begin
        if (!tx)
          w[F_LSB +: 8] = v.f;
      end
      // RL7 frames per multiframe
      REG_CFG2:
      begin
        if (!tx)
          w[K_LSB +: 5] = v.k;
      end
      // RL8 link and lane ids
      REG_CFG3:
      begin
        w[L_LSB +: 5] = v.l;
        w[LID_LSB +: 5] = v.lid;
        w[BID_LSB +: 4] = v.bid;
        w[DID_LSB +: 8] = v.did;
      end
      // RL10 sample format
      REG_CFG4:
      begin
        w[CS_LSB +: 2] = v.cs;
        w[NT_LSB +: 5] = v.nt;
        w[N_LSB +: 5] = v.n;
        w[M_LSB +: 8] = v.m;
      end
      // RL11 density and samples
      REG_CFG5:
      begin
        w[CF_LSB +: 5] = v.cf;
        w[HD_BIT] = v.hd;
        w[S_LSB +: 5] = v.s;
        w[SCR_BIT] = v.scr;
      end
      // RL13 checksum and spares
      REG_CFG6:
      begin
        w[CHK_LSB +: 8] = v.chk;
        w[RES2_LSB +: 8] = v.res2;
        w[RES1_LSB +: 8] = v.res1;
      end
      default:
      begin
      end
    endcase
    return w;
  endfunction

  // Alignment configuration octets sent on one lane
  function automatic logic [OCT_W-1:0] ila_pack(input ilc_lane_t v);
    logic [OCT_W-1:0] o;
    o = '0;
    o[8*OCT_DID +: 8] = v.did;
    o[8*OCT_BID +: 4] = v.bid;
    o[8*OCT_LID +: 5] = v.lid;
    o[8*OCT_L +: 5] = v.l;
    o[8*OCT_L + POS_TOP] = v.scr;
    o[8*OCT_F +: 8] = v.f;
    o[8*OCT_K +: 5] = v.k;
    o[8*OCT_M +: 8] = v.m;
    o[8*OCT_CSN +: 5] = v.n;
    o[8*OCT_CSN + POS_CS +: 2] = v.cs;
    o[8*OCT_NP +: 5] = v.nt;
    o[8*OCT_NP + POS_HI3 +: 3] = v.subclass;
    o[8*OCT_S +: 5] = v.s;
    o[8*OCT_S + POS_HI3 +: 3] = v.jesdv;
    o[8*OCT_CF +: 5] = v.cf;
    o[8*OCT_CF + POS_TOP] = v.hd;
    o[8*OCT_RES1 +: 8] = v.res1;
    o[8*OCT_RES2 +: 8] = v.res2;
    o[8*OCT_CHK +: 8] = v.chk;
    return o;
  endfunction

  always_comb
  begin
    nxt_s = s_ff;
    // RL15 core setup masked
    if (wr_en && core_hit)
      nxt_s.core = wdata & CORE_WR_MASK;
    // Data valid only in the cycle after the strobe
    nxt_s.rdata = '0;
    if (rd_en && core_hit)
      nxt_s.rdata = s_ff.core;
    else if (rd_en && lane_hit)
      nxt_s.rdata = rd_word(lane_q[lane_sel], reg_sel, tx_mode);
    // RL14 spares and ids go out on all lanes
    for (int i = 0; i < NUM_LANES; i++)
      nxt_s.tx_oct[i*OCT_W +: OCT_W] = tx_mode ? ila_pack(lane_q[i]) : '0;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      s_ff <= '{core: CORE_RST, default: '0};
    else
      s_ff <= nxt_s;
  end

  assign rdata = s_ff.rdata;
  assign tx_ila_octets = s_ff.tx_oct;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_wr_at(logic [2:0] ln, logic [3:0] r);
    wr_en && addr == {LANE_REGION, ln, r, 2'b00};
  endsequence

  sequence s_rd_at(logic [2:0] ln, logic [3:0] r);
    rd_en && addr == {LANE_REGION, ln, r, 2'b00};
  endsequence

  sequence s_quiet_l2;
    !(rx_ila_valid[2] && !tx_mode);
  endsequence

  AST_LANE_IDENTIFIER_WRITE: assert property ( // RL1
    s_wr_at(3'h3, REG_LANE_IDENTIFIER) |=> lane_q[3].lane_identifier == $past(wdata[4:0]))
    else $error("lane_identifier write not stored");

  AST_RX_CAPTURE: assert property ( // RL3
    rx_ila_valid[2] && !tx_mode
    |=> lane_q[2].f == $past(rx_ila_octets[2*OCT_W + 8*OCT_F +: 8])
     && lane_q[2].chk == $past(rx_ila_octets[2*OCT_W + 8*OCT_CHK +: 8]))
    else $error("received alignment parameters not captured");

  AST_CFG0_READ: assert property ( // RL4
    s_rd_at(3'h2, REG_CFG0) ##0 !tx_mode
    |=> rdata == {21'h0, $past(lane_q[2].jesdv), 5'h0, $past(lane_q[2].subclass)})
    else $error("word 0 read data wrong");

  AST_TX_UNUSED: assert property ( // RL5
    (s_rd_at(3'h2, REG_CFG1) or s_rd_at(3'h2, REG_CFG2)) ##0 tx_mode
    |=> rdata == 32'h0000_0000)
    else $error("unused transmit word not zero");

  AST_F_READ: assert property ( // RL6
    s_rd_at(3'h2, REG_CFG1) ##0 !tx_mode |=> rdata == {24'h0, $past(lane_q[2].f)})
    else $error("word 1 read data wrong");

  AST_K_READ: assert property ( // RL7
    s_rd_at(3'h2, REG_CFG2) ##0 !tx_mode |=> rdata == {27'h0, $past(lane_q[2].k)})
    else $error("word 2 read data wrong");

  AST_TX_LID: assert property ( // RL8
    $past(tx_mode) && tx_mode
    |-> lane_q[3].lid == $past(lane_q[3].lane_identifier)
     && lane_q[3].l == $past(s_ff.core[CORE_L_LSB +: 5]))
    else $error("transmit lane_identifier or count not generated");

  AST_TX_DID_ALL: assert property ( // RL9
    tx_mode && wr_en && addr == {LANE_REGION, 3'h0, REG_CFG3, 2'b00} && !$rose(tx_mode)
    |=> lane_q[0].did == $past(wdata[7:0]) && lane_q[7].bid == $past(wdata[11:8])
    ##1 tx_ila_octets[8*OCT_DID +: 8] == $past(wdata[7:0], 2))
    else $error("device id not sent on all lanes");

  AST_FMT_WRITE: assert property ( // RL10
    s_wr_at(3'h2, REG_CFG4) ##0 s_quiet_l2
    |=> lane_q[2].cs == $past(wdata[25:24]) && lane_q[2].m == $past(wdata[7:0]))
    else $error("sample format write not stored");

  AST_HD_WRITE: assert property ( // RL11
    s_wr_at(3'h2, REG_CFG5) ##0 s_quiet_l2
    |=> lane_q[2].hd == $past(wdata[16]) && lane_q[2].cf == $past(wdata[28:24]))
    else $error("density word write not stored");

  AST_SCR_RO: assert property ( // RL12
    $past(tx_mode) && tx_mode |-> lane_q[0].scr == $past(s_ff.core[CORE_SCR_BIT]))
    else $error("transmit scrambling bit not from core setup");

  AST_TX_CHK: assert property ( // RL13
    $past(tx_mode) && tx_mode |-> lane_q[5].chk == $past(ilc_fchk(lane_q[5])))
    else $error("transmit checksum wrong");

  AST_SPARE_WRITE: assert property ( // RL14
    s_wr_at(3'h2, REG_CFG6) ##0 s_quiet_l2
    |=> lane_q[2].res1 == $past(wdata[7:0]) && lane_q[2].res2 == $past(wdata[15:8]))
    else $error("spare byte write not stored");

  AST_RESERVED_ZERO: assert property ( // RL15
    s_rd_at(3'h2, REG_LANE_IDENTIFIER)
    |=> rdata[31:5] == 27'h0 && rdata[4:0] == $past(lane_q[2].lane_identifier))
    else $error("reserved bits not zero");

  // Lane 2 carries the directed receive traffic, so the capture, read and word 3 to 6 write checks watch it
  AST_RDATA_IDLE: assert property ( // RL15
    !rd_en |=> rdata == 32'h0000_0000)
    else $error("read data not cleared without a read");

  AST_UNMAPPED_READ: assert property ( // RL15
    rd_en && !core_hit && !lane_hit |=> rdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  AST_TX_OCT_IDLE: assert property ( // RL3
    !tx_mode |=> tx_ila_octets == '0)
    else $error("transmit octets not quiet in receive mode");

  AST_RX_REFUSED_TX: assert property ( // RL3
    tx_mode && rx_ila_valid[1] && !wr_en
    |=> lane_q[1].did == $past(lane_q[1].did) && lane_q[1].m == $past(lane_q[1].m))
    else $error("capture taken in transmit mode");

  AST_RX_CAPTURE_HI: assert property ( // RL4
    rx_ila_valid[2] && !tx_mode
    |=> lane_q[2].scr == $past(rx_ila_octets[2*OCT_W + 8*OCT_L + POS_TOP])
     && lane_q[2].jesdv == $past(rx_ila_octets[2*OCT_W + 8*OCT_S + POS_HI3 +: 3]))
    else $error("received version or scrambling not captured");

  AST_TX_GEN: assert property ( // RL5
    $past(tx_mode) && tx_mode
    |-> lane_q[2].jesdv == JESDV_REV_B
     && lane_q[2].subclass == $past(s_ff.core[CORE_SUB_LSB +: 3])
     && lane_q[2].f == $past(s_ff.core[CORE_F_LSB +: 8])
     && lane_q[2].k == $past(s_ff.core[CORE_K_LSB +: 5]))
    else $error("transmit link parameters not generated");

  AST_RX_L_RO: assert property ( // RL8
    s_wr_at(3'h2, REG_CFG3) ##0 s_quiet_l2 ##0 !tx_mode
    |=> lane_q[2].l == $past(lane_q[2].l) && lane_q[2].lid == $past(lane_q[2].lid))
    else $error("lane count or id changed by a write");

  AST_DID_WRITE: assert property ( // RL9
    s_wr_at(3'h2, REG_CFG3) ##0 s_quiet_l2
    |=> lane_q[2].did == $past(wdata[7:0]) && lane_q[2].bid == $past(wdata[11:8]))
    else $error("bank or device id write not stored");

  AST_CFG5_READ: assert property ( // RL11
    s_rd_at(3'h2, REG_CFG5)
    |=> rdata == {3'h0, $past(lane_q[2].cf), 7'h0, $past(lane_q[2].hd), 3'h0,
                  $past(lane_q[2].s), 7'h0, $past(lane_q[2].scr)})
    else $error("word 5 read data wrong");

  AST_SCR_NO_WRITE: assert property ( // RL12
    s_wr_at(3'h2, REG_CFG5) ##0 s_quiet_l2 ##0 !tx_mode
    |=> lane_q[2].scr == $past(lane_q[2].scr))
    else $error("scrambling bit changed by a write");

  AST_CHK_NO_WRITE: assert property ( // RL13
    s_wr_at(3'h2, REG_CFG6) ##0 s_quiet_l2 ##0 !tx_mode
    |=> lane_q[2].chk == $past(lane_q[2].chk))
    else $error("checksum changed by a write");

  AST_TX_OCT_LANE: assert property ( // RL14
    $past(tx_mode)
    |-> tx_ila_octets[2*OCT_W + 8*OCT_RES1 +: 8] == $past(lane_q[2].res1)
     && tx_ila_octets[2*OCT_W + 8*OCT_CHK +: 8] == $past(lane_q[2].chk))
    else $error("transmit octets do not follow lane registers");
endmodule
`default_nettype wire

//--- verif/ilc_conv_model.sv
`default_nettype none
module ilc_conv_model
  import ilc_pkg::*;
(
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  input  wire logic                       send,
  input  wire logic [2:0]                 send_lane,
  input  wire logic [OCT_W-1:0]           send_oct,
  output logic      [NUM_LANES-1:0]       rx_ila_valid,
  output logic      [NUM_LANES*OCT_W-1:0] rx_ila_octets
);
  timeunit 1ns;
  timeprecision 100ps;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_ila_valid  <= '0;
      rx_ila_octets <= '0;
    end
    else
    begin
      // Idle lanes toggle, so stale octets never look valid
      rx_ila_octets <= ~rx_ila_octets;
      rx_ila_valid  <= '0;
      if (send)
      begin
        rx_ila_valid[send_lane]                  <= 1'b1;
        rx_ila_octets[send_lane*OCT_W +: OCT_W] <= send_oct;
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/ilc_ila_regs_tb_top.sv
`default_nettype none
module ilc_ila_regs_tb_top
  import ilc_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  logic                       clk_sys = 1'b0;
  logic                       rst_n = 1'b0;
  logic [11:0]                addr = '0;
  logic [31:0]                wdata = '0;
  logic                       wr_en = 1'b0;
  logic                       rd_en = 1'b0;
  logic [31:0]                rdata;
  logic [NUM_LANES-1:0]       rx_ila_valid;
  logic [NUM_LANES*OCT_W-1:0] rx_ila_octets;
  logic [NUM_LANES*OCT_W-1:0] tx_ila_octets;
  logic                       send = 1'b0;
  logic [2:0]                 send_lane = '0;
  logic [OCT_W-1:0]           send_oct = '0;
  int                         n_mismatch = 0;
  int                         cmp_count = 0;

  always #4 clk_sys = ~clk_sys;

  ilc_ila_regs u_ilc_ila_regs (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .addr          (addr),
    .wdata         (wdata),
    .wr_en         (wr_en),
    .rd_en         (rd_en),
    .rdata         (rdata),
    .rx_ila_valid  (rx_ila_valid),
    .rx_ila_octets (rx_ila_octets),
    .tx_ila_octets (tx_ila_octets)
  );

  ilc_conv_model u_ilc_conv_model (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .send          (send),
    .send_lane     (send_lane),
    .send_oct      (send_oct),
    .rx_ila_valid  (rx_ila_valid),
    .rx_ila_octets (rx_ila_octets)
  );

  function automatic logic [11:0] la(input int ln, input int ix);
    la = 12'h800 + 12'(ln * 64 + ix * 4);
  endfunction

  function automatic logic [7:0] sum8(input ilc_lane_t v);
    sum8 = v.did + 8'(v.bid) + 8'(v.lid) + 8'(v.scr) + 8'(v.l) + v.f + 8'(v.k)
         + v.m + 8'(v.cs) + 8'(v.n) + 8'(v.subclass) + 8'(v.nt) + 8'(v.jesdv)
         + 8'(v.s) + 8'(v.hd) + 8'(v.cf) + v.res1 + v.res2;
  endfunction

  function automatic logic [31:0] word(input ilc_lane_t v, input int ix);
    case (ix)
      0: word = {27'h0, v.lane_identifier};
      1: word = {21'h0, v.jesdv, 5'h0, v.subclass};
      2: word = {24'h0, v.f};
      3: word = {27'h0, v.k};
      4: word = {3'h0, v.l, 3'h0, v.lid, 4'h0, v.bid, v.did};
      5: word = {6'h0, v.cs, 3'h0, v.nt, 3'h0, v.n, v.m};
      6: word = {3'h0, v.cf, 7'h0, v.hd, 3'h0, v.s, 7'h0, v.scr};
      default: word = {8'h0, v.chk, v.res2, v.res1};
    endcase
  endfunction

  // Octet 0 lowest, checksum in octet 13
  function automatic logic [OCT_W-1:0] oct(input ilc_lane_t v);
    oct = {v.chk, v.res2, v.res1, v.hd, 2'h0, v.cf, v.jesdv, v.s, v.subclass, v.nt,
           v.cs, 1'h0, v.n, v.m, 3'h0, v.k, v.f, v.scr, 2'h0, v.l, 3'h0, v.lid,
           4'h0, v.bid, v.did};
  endfunction

  task automatic test_done();
    $display("Mismatches %0d in %0d compares", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [OCT_W-1:0] got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    @(posedge clk_sys);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 q = rdata;
  endtask

  task automatic snd(input logic [2:0] ln, input logic [OCT_W-1:0] o);
    @(posedge clk_sys);
    send      <= 1'b1;
    send_lane <= ln;
    send_oct  <= o;
    @(posedge clk_sys);
    send      <= 1'b0;
  endtask

  // Transmit hides words 0 to 2
  task automatic cmp_lane(input int ln, input ilc_lane_t v, input logic tx);
    logic [31:0] d;
    for (int ix = 0; ix < 8; ix++)
    begin
      rd(la(ln, ix), d);
      chk("lane word", OCT_W'(d), OCT_W'((tx && ix > 0 && ix < 4) ? 32'h0 : word(v, ix)));
    end
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    test_done();
  end

  initial
  begin
    ilc_lane_t   v;
    ilc_lane_t   t;
    logic [31:0] d;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int ln = 0; ln < 8; ln++)
    begin
      v = '0;
      v.lane_identifier = 5'(ln);
      cmp_lane(ln, v, 1'b0);
    end
    wr(la(3, 0), 32'hFFFF_FFF5);
    rd(la(3, 0), d);
    chk("lane_identifier", OCT_W'(d), 112'h15);
    rd(la(4, 0), d);
    chk("lane_identifier kept", OCT_W'(d), 112'h4);
    wr(12'h7FC, 32'hFFFF_FFFF);
    rd(12'h7FC, d);
    chk("unmapped", OCT_W'(d), 112'h0);
    rd(la(7, 8), d);
    chk("lane hole", OCT_W'(d), 112'h0);
    // Repeating 0xB7 pattern so most fields hold a mix of ones and zeros; jesdv, cs, hd and scr are all ones
    v = ilc_lane_t'({{12{8'hB7}}, 6'h37});
    v.lane_identifier = 5'h2;
    snd(3'h2, oct(v));
    cmp_lane(2, v, 1'b0);
    rd(la(5, 5), d);
    chk("other lane", OCT_W'(d), 112'h0);
    for (int ix = 4; ix < 8; ix++)
      wr(la(2, ix), 32'hFFFF_FFFF);
    {v.bid, v.did, v.cs, v.nt, v.n, v.m} = 32'hFFFF_FFFF;
    {v.cf, v.hd, v.s, v.res2, v.res1} = 27'h7FF_FFFF;
    cmp_lane(2, v, 1'b0);
    // Transmit: scrambling on, subclass 1, four lanes, F-1 0x12, K-1 0x1F
    wr(ADDR_CORE_CFG, 32'h1F12_0313);
    wr(la(0, 4), 32'hFFFF_F6A5);
    wr(la(5, 5), 32'h0207_0B3F);
    wr(la(1, 6), 32'h1E01_0700);
    wr(la(7, 7), 32'hFFFF_3C4D);
    snd(3'h1, oct(v));
    repeat (4) @(posedge clk_sys);
    #1;
    t = '0;
    t.jesdv = JESDV_REV_B;
    t.subclass = 3'h1;
    t.f = 8'h12;
    t.k = 5'h1F;
    t.l = 5'h3;
    t.scr = 1'b1;
    {t.bid, t.did} = 12'h6A5;
    {t.cs, t.nt, t.n, t.m} = {2'h2, 5'h07, 5'h0B, 8'h3F};
    {t.cf, t.hd, t.s} = {5'h1E, 1'b1, 5'h07};
    {t.res2, t.res1} = 16'h3C4D;
    for (int ln = 0; ln < 8; ln++)
    begin
      t.lid = (ln == 3) ? 5'h15 : 5'(ln);
      t.lane_identifier = t.lid;
      t.chk = sum8(t);
      chk("tx octets", tx_ila_octets[ln*OCT_W +: OCT_W], oct(t));
      cmp_lane(ln, t, 1'b1);
    end
    wr(ADDR_CORE_CFG, 32'h0);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("tx idle", tx_ila_octets[2*OCT_W +: OCT_W], 112'h0);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(la(3, 0), d);
    chk("id after reset", OCT_W'(d), 112'h3);
    rd(la(0, 4), d);
    chk("word 3 after reset", OCT_W'(d), 112'h0);
    test_done();
  end
endmodule
`default_nettype wire
